/* File: core/pao_consts.svh */
// Constants of the pipelined converter output formatter.
`ifndef PAO_CONSTS_SVH
`define PAO_CONSTS_SVH

// Output word width and number of two-bit pipeline stages.
`define PAO_WIDTH        10
`define PAO_NSTAGE       9
`define PAO_RES_W        12

// Latency in tenths of a convert cycle, and the sub-clock edges it takes.
`define PAO_LATENCY_X10  65
`define PAO_LAT_SUB      ((`PAO_LATENCY_X10 * 2) / 10)

// Residue thresholds and reference step, in output code units.
`define PAO_THR_HI       12'sh080
`define PAO_THR_LO       12'shF80
`define PAO_REF          12'sh200
`define PAO_RES_MAX      12'sh1FF
`define PAO_RES_MIN      12'shE00

// Mid-scale input level, which maps to residue zero.
`define PAO_MIDSCALE     10'h200

// Reset values.
`define PAO_DATA_RST     10'h000
`define PAO_RES_RST      12'sh000

`endif

/* File: core/pao_formatter.sv */
// Digital side of a ten-bit pipelined converter: stages, alignment, output.
`timescale 1ns/1ns
`include "pao_consts.svh"

// Functional notes
// - Output word for a sample appears 6.5 convert cycles after its start.
// - Each conversion result is a 10-bit parallel word.
// - Offset binary: positive full scale gives all ones.
// - Coding select low or open gives offset binary.
// - Coding select high gives two's complement by inverting the top bit.
// - Output disable high puts all data outputs in high impedance.
// - Output disable low or open drives the data outputs normally.
// - Nine pipeline stages, each a two-bit quantizer and feedback converter.
// - Stages advance on a sub-clock at twice the convert clock rate.
// - Each stage result except the last is delayed to align with the last stage.
// - Redundant digits are combined so no output code goes missing.
// - Sample in the first non-overlapping phase, hold in the second.
module pao_formatter
    import pao_pkg::*;
#(
    parameter int NSTAGE  = `PAO_NSTAGE,
    parameter int LAT_SUB = `PAO_LAT_SUB
)
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [9:0]  sample_in,
    input  wire logic        top_bit_invert_select,
    input  wire logic        output_disable,
    output logic             track_phase,
    output logic             hold_phase,
    output logic             data_strobe,
    output logic [9:0]       data_out,
    output logic             data_oe_n
);

    // Register stages between the corrector and the output word.
    localparam int PAD = LAT_SUB - NSTAGE - 2;

    pao_sh_phase_t           phase_reg;
    pao_sh_phase_t           phase_next;
    wire                     take_w;
    logic signed [11:0]      hold_reg;
    logic signed [11:0]      hold_next;
    logic signed [11:0]      res_w [0:NSTAGE];
    logic [1:0]              dig_w [0:NSTAGE-1];
    logic [1:0]              al_w [0:NSTAGE-1];
    logic signed [11:0]      term_w [0:NSTAGE-1];
    logic signed [11:0]      sum_w [0:NSTAGE];
    logic signed [11:0]      corr_next;
    logic [9:0]              corr_reg;
    logic [9:0]              pad_reg [0:PAD-1];
    logic [LAT_SUB-1:0]      vld_reg;
    logic [9:0]              data_reg;
    logic [9:0]              data_next;
    logic                    upd_reg;

    // The clock is the sub-clock; two of its edges make one convert cycle,
    // so each sub-clock edge advances the pipeline by one stage.
    assign phase_next = (phase_reg == PAO_SH_TRACK) ? PAO_SH_HOLD
                                                    : PAO_SH_TRACK;
    assign take_w      = (phase_reg == PAO_SH_TRACK);
    assign track_phase = (phase_reg == PAO_SH_TRACK);
    assign hold_phase  = (phase_reg == PAO_SH_HOLD);

    // The held value only changes in the track phase, so stage one sees a
    // steady input through the hold phase.
    assign hold_next = take_w ? ($signed({2'b00, sample_in})
                                 - $signed({2'b00, `PAO_MIDSCALE}))
                              : hold_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_reg <= PAO_SH_TRACK;
            hold_reg  <= `PAO_RES_RST;
        end
        else
        begin
            phase_reg <= phase_next;
            hold_reg  <= hold_next;
        end
    end

    assign res_w[0] = hold_reg;
    assign sum_w[0] = `PAO_RES_RST;

    genvar gi;
    generate
        for (gi = 0; gi < NSTAGE; gi = gi + 1)
        begin : g_stage
            localparam int DEPTH = NSTAGE - 1 - gi;

            pao_stage pao_stage_inst
            (
                .clk       (clk),
                .rstn      (rstn),
                .res_in    (res_w[gi]),
                .res_reg   (res_w[gi+1]),
                .digit_reg (dig_w[gi])
            );

            if (DEPTH == 0)
            begin : g_nodelay
                assign al_w[gi] = dig_w[gi];
            end
            else
            begin : g_delay
                logic [1:0] dl_reg [0:DEPTH-1];

                always_ff @(posedge clk or negedge rstn)
                begin
                    if (!rstn)
                    begin
                        for (int k = 0; k < DEPTH; k++)
                        begin
                            dl_reg[k] <= PAO_DIG_ZERO;
                        end
                    end
                    else
                    begin
                        dl_reg[0] <= dig_w[gi];
                        for (int k = 1; k < DEPTH; k++)
                        begin
                            dl_reg[k] <= dl_reg[k-1];
                        end
                    end
                end

                assign al_w[gi] = dl_reg[DEPTH-1];
            end

            // Each digit is -1, 0 or +1 at its binary weight; the overlap
            // between neighbouring stages absorbs comparator offsets.
            assign term_w[gi] = ($signed({10'h000, al_w[gi]}) - 12'sh001)
                                <<< DEPTH;
            assign sum_w[gi+1] = sum_w[gi] + term_w[gi];
        end
    endgenerate

    // The sign of the final residue acts as the last, redundant bit.
    assign corr_next = sum_w[NSTAGE] + `PAO_REF
                       - $signed({11'h000, res_w[NSTAGE][11]});

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            corr_reg <= `PAO_DATA_RST;
            for (int k = 0; k < PAD; k++)
            begin
                pad_reg[k] <= `PAO_DATA_RST;
            end
        end
        else
        begin
            corr_reg   <= corr_next[9:0];
            pad_reg[0] <= corr_reg;
            for (int k = 1; k < PAD; k++)
            begin
                pad_reg[k] <= pad_reg[k-1];
            end
        end
    end

    // The output word only loads when a real sample reaches the end, so the
    // duplicate entries made during hold phases never show.
    assign data_next = vld_reg[LAT_SUB-1] ? pad_reg[PAD-1]
                                          : data_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            vld_reg  <= '0;
            data_reg <= `PAO_DATA_RST;
            upd_reg  <= 1'b0;
        end
        else
        begin
            vld_reg  <= {vld_reg[LAT_SUB-2:0], take_w};
            data_reg <= data_next;
            upd_reg  <= vld_reg[LAT_SUB-1];
        end
    end

    assign data_strobe = upd_reg;

    // Coding and disable act at the pins without a register; both controls
    // are meant to be static, so a change mid-stream is not resynchronised.
    assign data_out  = data_reg
                       ^ {top_bit_invert_select, 9'h000};
    assign data_oe_n = output_disable;

    // Counts edges since reset so the first word can be held to its
    // latency; it saturates one past the latency and then stays there.
    localparam int FILL = LAT_SUB + 1;

    logic [4:0]              fill_reg;
    logic [4:0]              fill_next;

    assign fill_next = (fill_reg == 5'(FILL)) ? fill_reg
                                              : fill_reg + 5'h01;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fill_reg <= 5'h00;
        end
        else
        begin
            fill_reg <= fill_next;
        end
    end

    sequence s_track_hold;
        (track_phase && !hold_phase) ##1 (hold_phase && !track_phase);
    endsequence

    AST_PHASES: assert property (
        @(posedge clk) disable iff (!rstn)
        track_phase |-> s_track_hold ##1 track_phase)
        else $error("Track and hold phases overlap or skip.");

    AST_LATENCY: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(vld_reg[LAT_SUB-1]) |-> data_reg == $past(sample_in, 14))
        else $error("Output word does not match sample 6.5 cycles back.");

    AST_CORRECTED: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(vld_reg[NSTAGE]) |-> corr_reg == $past(sample_in, 11))
        else $error("Corrected code differs from the sampled level.");

    AST_ALIGN: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(vld_reg[NSTAGE-1]) |-> al_w[0] == $past(dig_w[0], 8))
        else $error("First stage digit not aligned with the last stage.");

    AST_FULL_SCALE: assert property (
        @(posedge clk) disable iff (!rstn)
        ($past(vld_reg[LAT_SUB-1]) && $past(sample_in, 14) == 10'h3FF
            && !top_bit_invert_select) |-> data_out == 10'h3FF)
        else $error("Positive full scale is not all ones.");

    AST_OFFSET_BINARY: assert property (
        @(posedge clk) disable iff (!rstn)
        ($past(vld_reg[LAT_SUB-1]) && !top_bit_invert_select)
            |-> data_out == $past(sample_in, 14))
        else $error("Offset binary word is wrong.");

    AST_TWOS_COMP: assert property (
        @(posedge clk) disable iff (!rstn)
        ($past(vld_reg[LAT_SUB-1]) && top_bit_invert_select)
            |-> data_out == ($past(sample_in, 14) ^ 10'h200))
        else $error("Two's complement word is wrong.");

    // The disable acts in reset as well, where a test may exercise it.
    AST_HIZ: assert property (
        @(posedge clk)
        output_disable |-> data_oe_n)
        else $error("Outputs driven while disabled.");

    AST_DRIVE: assert property (
        @(posedge clk)
        !output_disable |-> !data_oe_n)
        else $error("Outputs released while enabled.");

    AST_ONCE_PER_CYCLE: assert property (
        @(posedge clk) disable iff (!rstn)
        data_strobe |=> !data_strobe ##1 data_strobe)
        else $error("Output update rate is not once per convert cycle.");

    AST_ONLY_ON_LOAD: assert property (
        @(posedge clk) disable iff (!rstn)
        !$stable(data_reg) |-> data_strobe)
        else $error("Output word changed between loads.");

    AST_FIRST_WORD: assert property (
        @(posedge clk) disable iff (!rstn)
        data_strobe |-> fill_reg == 5'(FILL))
        else $error("Output word strobed before the pipeline filled.");

    AST_FIRST_WORD_DUE: assert property (
        @(posedge clk) disable iff (!rstn)
        (fill_reg == 5'(LAT_SUB)) |=> data_strobe)
        else $error("First output word is late.");

    AST_STROBE_TRACK: assert property (
        @(posedge clk) disable iff (!rstn)
        data_strobe |-> track_phase)
        else $error("Output word loaded out of step with the convert cycle.");

    // An exact input leaves only zero or minus one step in the last stage.
    AST_LAST_RESIDUE: assert property (
        @(posedge clk) disable iff (!rstn)
        (res_w[NSTAGE] == `PAO_RES_RST)
            || (res_w[NSTAGE] == `PAO_RES_MIN))
        else $error("Final residue is not zero or minus one step.");

    AST_HOLD_STEADY: assert property (
        @(posedge clk) disable iff (!rstn)
        hold_phase |=> $stable(hold_reg))
        else $error("Held input changed during the hold phase.");

endmodule

/* File: core/pao_pkg.sv */
// Types shared by the converter output formatter files.
package pao_pkg;

    typedef enum logic [1:0]
    {
        PAO_DIG_NEG  = 2'b00,
        PAO_DIG_ZERO = 2'b01,
        PAO_DIG_POS  = 2'b10
    } pao_digit_t;

    typedef enum logic [1:0]
    {
        PAO_SH_TRACK = 2'b01,
        PAO_SH_HOLD  = 2'b10
    } pao_sh_phase_t;

endpackage

/* File: core/pao_stage.sv */
// One two-bit redundant pipeline stage: quantizer, feedback step, residue.
`timescale 1ns/1ns
`include "pao_consts.svh"

module pao_stage
    import pao_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic signed [11:0] res_in,
    output logic signed [11:0]      res_reg,
    output logic [1:0]              digit_reg
);

    wire                    above_w;
    wire                    below_w;
    wire signed [11:0]      twice_w;
    logic signed [11:0]     res_next;
    logic [1:0]             digit_next;

    assign above_w = (res_in >= `PAO_THR_HI);
    assign below_w = (res_in < `PAO_THR_LO);
    assign twice_w = res_in <<< 1;

    // The feedback converter subtracts one reference step for a positive digit, adds one for a negative digit.
    assign res_next = above_w ? (twice_w - `PAO_REF) :
                      below_w ? (twice_w + `PAO_REF) : twice_w;
    assign digit_next = above_w ? PAO_DIG_POS :
                        below_w ? PAO_DIG_NEG : PAO_DIG_ZERO;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            res_reg   <= `PAO_RES_RST;
            digit_reg <= PAO_DIG_ZERO;
        end
        else
        begin
            res_reg   <= res_next;
            digit_reg <= digit_next;
        end
    end

    AST_STAGE_DIGIT: assert property (
        @(posedge clk) disable iff (!rstn)
        (digit_reg == PAO_DIG_POS) |-> ($past(res_in) >= `PAO_THR_HI))
        else $error("Positive digit without input above threshold.");

    AST_STAGE_RANGE: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(res_in) inside {[`PAO_RES_MIN:`PAO_RES_MAX]} |->
            res_reg inside {[`PAO_RES_MIN:`PAO_RES_MAX]})
        else $error("Stage residue left the redundant range.");

endmodule

/* File: sim/pao_capture.sv */
// Far-side capturing logic that latches each word from the data pins.
`timescale 1ns/1ns

module pao_capture
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       data_strobe,
    input  wire logic [9:0] data_pin,
    output logic [9:0]      word_reg,
    output int              word_count
);
    // The pins are read only on the strobe cycle, since the word is held
    // for a whole convert cycle and nothing else qualifies it.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            word_reg <= 10'h000;
            word_count <= 0;
        end
        else if (data_strobe)
        begin
            word_reg <= data_pin;
            word_count <= word_count + 1;
        end
    end
endmodule

/* File: sim/test_pipelined_adc_output_formatter.sv */
// Self-checking bench for the pipelined converter output formatter.
`timescale 1ns/1ns

module test_pipelined_adc_output_formatter;
    logic       clk;
    logic       rstn;
    logic       sel;
    logic       dis;
    logic [9:0] sample_in;
    logic       track_phase;
    logic       hold_phase;
    logic       data_strobe;
    logic [9:0] data_out;
    logic       data_oe_n;
    logic [9:0] word_reg;
    wire  [9:0] data_pin;
    int         word_count;
    int         num_errors;
    int         checked;
    int         ecnt;
    int         m;
    int         c0;
    logic [9:0] hist [0:1023];
    logic       hv [0:1023];

    // The pin floats when the output enable is released.
    assign data_pin = data_oe_n ? 10'hZZZ : data_out;

    pao_formatter pao_formatter_inst (.clk(clk), .rstn(rstn),
        .sample_in(sample_in), .top_bit_invert_select(sel),
        .output_disable(dis), .track_phase(track_phase),
        .hold_phase(hold_phase), .data_strobe(data_strobe),
        .data_out(data_out), .data_oe_n(data_oe_n));

    pao_capture pao_capture_inst (.clk(clk), .rstn(rstn),
        .data_strobe(data_strobe), .data_pin(data_pin),
        .word_reg(word_reg), .word_count(word_count));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [9:0] exp,
                       input logic [9:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Every strobed word must be the sample taken thirteen edges earlier.
    always @(posedge clk)
    begin
        if (rstn === 1'b1 && track_phase === 1'b1)
        begin
            hist[ecnt % 1024] = sample_in;
            hv[ecnt % 1024] = 1'b1;
        end
        m = ecnt;
        ecnt++;
        #2;
        if (rstn === 1'b1 && data_strobe !== 1'b0)
        begin
            if (m < 13 || hv[(m - 13) % 1024] !== 1'b1)
                chk("early strobe", 10'h000, 10'h3FF);
            else
                chk("word", hist[(m - 13) % 1024] ^ {sel, 9'h000},
                    data_out);
        end
    end

    task automatic do_reset();
        @(negedge clk);
        rstn = 1'b0;
        for (int i = 0; i < 1024; i++)
            hv[i] = 1'b0;
        #1;
        chk("reset strobe", 10'h000, {9'h000, data_strobe});
        chk("reset phase", 10'h001, {8'h00, hold_phase, track_phase});
        chk("reset word", {sel, 9'h000}, data_out);
        repeat (2) @(negedge clk);
        rstn = 1'b1;
    endtask

    task automatic run_stream(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk);
            sample_in = 10'((i * 91 + 7) % 1024);
        end
    endtask

    task automatic t_stream();
        run_stream(30);
        c0 = word_count;
        run_stream(40);
        chk("word rate", 10'd20, 10'(word_count - c0));
    endtask

    task automatic t_level(input logic [9:0] lvl, input logic [9:0] exp);
        @(negedge clk);
        sample_in = lvl;
        repeat (20) @(negedge clk);
        chk("level word", exp, data_out);
        chk("captured word", exp, word_reg);
    endtask

    task automatic t_phases();
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            chk("phase pair", {9'h000, ~track_phase},
                {9'h000, hold_phase});
            c0 = track_phase;
            @(negedge clk);
            chk("phase toggle", {9'h000, ~c0[0]},
                {9'h000, track_phase});
        end
    endtask

    // Output disable is a test feature: it only moves while reset holds
    // the pipeline, so no conversion is running when it changes.
    task automatic t_disable();
        @(negedge clk);
        rstn = 1'b0;
        dis = 1'b1;
        #1;
        chk("pins floating", 10'hZZZ, data_pin);
        @(negedge clk);
        dis = 1'b0;
        #1;
        chk("pins driven", {sel, 9'h000}, data_pin);
        chk("enable low", 10'h000, {9'h000, data_oe_n});
    endtask

    task automatic t_twos();
        t_level(10'h3FF, 10'h3FF);
        @(negedge clk);
        sel = 1'b1;
        #1;
        chk("msb flip", 10'h1FF, data_out);
        t_level(10'h000, 10'h200);
        t_level(10'h200, 10'h000);
        run_stream(40);
        @(negedge clk);
        sel = 1'b0;
        t_level(10'h200, 10'h200);
        t_level(10'h000, 10'h000);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        rstn = 1'b0;
        sel = 1'b0;
        dis = 1'b0;
        sample_in = 10'h000;
        num_errors = 0;
        checked = 0;
        ecnt = 0;
        do_reset();
        t_phases();
        t_stream();
        t_twos();
        run_stream(9);
        t_disable();
        do_reset();
        t_stream();
        tally_and_finish();
    end

    initial
    begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
endmodule
